// ===== rtl/pwm_out_pkg.sv
package pwm_out_pkg;

  // Output mode encodings
  typedef enum logic [2:0] {
    MODE_OFF       = 3'b000,
    MODE_PP_COMP   = 3'b001,
    MODE_PP_FB4    = 3'b010,
    MODE_PP_FB6    = 3'b011,
    MODE_SKIP      = 3'b100,
    MODE_SKIP_COMP = 3'b101
  } out_mode_type;

  // Width of the dead-band counts
  localparam int DB_WIDTH = 8;

  // Values after reset
  localparam logic       RST_OUT    = 1'b0;
  localparam logic       RST_ODD    = 1'b1;
  localparam logic [7:0] RST_DB_CNT = 8'h00;
endpackage

// ===== rtl/pwm_sync2.sv
module pwm_sync2 (
  input  wire logic clk_i,   // Sampling clock
  input  wire logic rst_n_i, // Async reset, active low
  input  wire logic d_i,     // Asynchronous level
  output logic      q_o      // Synchronised level
);
  logic meta_q;

  // Two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// ===== rtl/pwm_dead_band.sv
module pwm_dead_band #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,   // Unit clock
  input  wire logic             rst_n_i, // Async reset, active low
  input  wire logic             start_i, // Start a dead-band delay
  input  wire logic             en_i,    // Dead-band enabled
  input  wire logic [WIDTH-1:0] len_i,   // Delay length in cycles
  output logic                  fire_o   // One-cycle pulse when delay ends
);
  logic [WIDTH-1:0] cnt_q;
  logic             busy_q;

  // Delay counter; restarts on a new start, fires immediately if disabled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= WIDTH'(pwm_out_pkg::RST_DB_CNT);
      busy_q <= 1'b0;
      fire_o <= 1'b0;
    end else begin
      fire_o <= 1'b0;
      if (start_i) begin
        if (!en_i || len_i == '0) begin
          busy_q <= 1'b0;
          fire_o <= 1'b1;
        end else begin
          busy_q <= 1'b1;
          cnt_q  <= len_i - WIDTH'(1);
        end
      end else if (busy_q) begin
        if (cnt_q == '0) begin
          busy_q <= 1'b0;
          fire_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - WIDTH'(1);
        end
      end
    end
  end
endmodule

// ===== rtl/pwm_push_pull_out.sv
module pwm_push_pull_out #(
  parameter int DB_W     = pwm_out_pkg::DB_WIDTH,
  parameter int N_SRC    = 4
) (
  input  wire logic             clk_sys_i,    // Unit clock, 250 MHz
  input  wire logic             reset_n_i,    // Async reset, active low
  input  wire logic             enable_i,     // Unit enabled
  input  wire logic [2:0]       mode_i,       // Output mode select
  input  wire logic             period_evt_i, // Period event pulse
  input  wire logic             rise_evt_i,   // Synchronous rising event
  input  wire logic             fall_evt_i,   // Falling event pulse
  input  wire logic [N_SRC-1:0] rise_src_i,   // Async rising sources
  input  wire logic [N_SRC-1:0] rise_src_en_i, // Rising source enables
  input  wire logic             db_rise_en_i, // Rising dead-band enable
  input  wire logic             db_fall_en_i, // Falling dead-band enable
  input  wire logic [DB_W-1:0]  db_rise_len_i, // Rising dead-band cycles
  input  wire logic [DB_W-1:0]  db_fall_len_i, // Falling dead-band cycles
  output logic                  drive_out_a_o, // Output A
  output logic                  drive_out_b_o, // Output B
  output logic                  drive_out_c_o, // Output C
  output logic                  drive_out_d_o, // Output D
  output logic                  drive_out_e_o, // Output E
  output logic                  drive_out_f_o, // Output F
  output logic                  odd_period_o  // Current period is odd
);

  logic                 rst_meta_q;
  logic                 rst_n_q;
  logic [N_SRC-1:0]     src_sync;
  logic                 en_q;
  logic                 odd_q;
  pwm_out_pkg::out_mode_type mode_sel;
  logic                 is_bridge;
  logic                 is_skip_any;
  logic                 qual_q;
  logic                 rise_ok;
  logic                 is_comp;
  logic                 is_fb4;
  logic                 is_fb6;
  logic                 is_skip;
  logic                 is_skc;
  logic                 use_db;
  logic                 db_r_start;
  logic                 db_f_start;
  logic                 db_r_fire;
  logic                 db_f_fire;
  logic                 rise_pair_q;
  logic                 fall_pair_q;
  logic                 a_q;
  logic                 b_q;
  logic                 e_q;
  logic                 f_q;

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Synchronise the asynchronous rising-edge sources
  genvar gi;
  generate
    for (gi = 0; gi < N_SRC; gi++) begin : g_src
      pwm_sync2 u_sync (
        .clk_i   (clk_sys_i),
        .rst_n_i (rst_n_q),
        .d_i     (rise_src_i[gi]),
        .q_o     (src_sync[gi])
      );
    end
  endgenerate

  // Mode decode; codes beyond the table select no mode at all
  assign mode_sel    = pwm_out_pkg::out_mode_type'(mode_i);
  assign is_comp     = (mode_sel == pwm_out_pkg::MODE_PP_COMP);
  assign is_fb4      = (mode_sel == pwm_out_pkg::MODE_PP_FB4);
  assign is_fb6      = (mode_sel == pwm_out_pkg::MODE_PP_FB6);
  assign is_skip     = (mode_sel == pwm_out_pkg::MODE_SKIP);
  assign is_skc      = (mode_sel == pwm_out_pkg::MODE_SKIP_COMP);
  assign is_bridge   = is_fb4 | is_fb6;
  assign is_skip_any = is_skip | is_skc;
  // Dead-band only where a complement exists, never in four-output mode
  assign use_db      = is_comp | is_fb6 | is_skc;

  // Enable history, to spot the start of a run
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      en_q <= 1'b0;
    end else begin
      en_q <= enable_i;
    end
  end

  // Period parity: first period after enable is odd
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      odd_q <= pwm_out_pkg::RST_ODD;
    end else if (enable_i && !en_q) begin
      odd_q <= pwm_out_pkg::RST_ODD;
    end else if (enable_i && period_evt_i) begin
      odd_q <= ~odd_q;
    end
  end

  // Pulse qualification at the period event
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      qual_q <= 1'b0;
    end else if (!enable_i) begin
      qual_q <= 1'b0;
    end else if (period_evt_i) begin
      qual_q <= |(src_sync & rise_src_en_i);
    end else if (rise_evt_i) begin
      qual_q <= 1'b0;
    end
  end

  // Skip modes take the rise only when qualified; others always
  assign rise_ok = is_skip_any ? qual_q : 1'b1;

  // Dead-band starts coincide with the inactive step of each transition
  assign db_r_start = enable_i & use_db & rise_evt_i & rise_ok;
  assign db_f_start = enable_i & use_db & fall_evt_i;

  // Rising dead-band timer
  pwm_dead_band #(.WIDTH(DB_W)) u_db_rise (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n_q),
    .start_i (db_r_start),
    .en_i    (db_rise_en_i),
    .len_i   (db_rise_len_i),
    .fire_o  (db_r_fire)
  );

  // Falling dead-band timer
  pwm_dead_band #(.WIDTH(DB_W)) u_db_fall (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n_q),
    .start_i (db_f_start),
    .en_i    (db_fall_en_i),
    .len_i   (db_fall_len_i),
    .fire_o  (db_f_fire)
  );

  // Pair that a pending rising dead-band belongs to
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rise_pair_q <= pwm_out_pkg::RST_ODD;
    end else if (db_r_start) begin
      rise_pair_q <= odd_q;
    end
  end

  // Pair that a pending falling dead-band belongs to
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fall_pair_q <= pwm_out_pkg::RST_ODD;
    end else if (db_f_start) begin
      fall_pair_q <= odd_q;
    end
  end

  // Output A: odd leg of push-pull, the primary in the skip modes
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      a_q <= pwm_out_pkg::RST_OUT;
    end else if (!enable_i) begin
      a_q <= pwm_out_pkg::RST_OUT;
    end else begin
      unique case (mode_sel)
        pwm_out_pkg::MODE_PP_COMP,
        pwm_out_pkg::MODE_PP_FB6: begin
          if (db_r_fire && rise_pair_q) begin
            a_q <= 1'b1;
          end else if (fall_evt_i && odd_q) begin
            a_q <= 1'b0;
          end
        end
        pwm_out_pkg::MODE_PP_FB4: begin
          if (fall_evt_i && odd_q) begin
            a_q <= 1'b0;
          end else if (rise_evt_i && odd_q) begin
            a_q <= 1'b1;
          end
        end
        pwm_out_pkg::MODE_SKIP: begin
          if (fall_evt_i) begin
            a_q <= 1'b0;
          end else if (rise_evt_i && rise_ok) begin
            a_q <= 1'b1;
          end
        end
        pwm_out_pkg::MODE_SKIP_COMP: begin
          if (fall_evt_i) begin
            a_q <= 1'b0;
          end else if (db_r_fire) begin
            a_q <= 1'b1;
          end
        end
        pwm_out_pkg::MODE_OFF: begin
          a_q <= pwm_out_pkg::RST_OUT;
        end
        default: begin
          a_q <= pwm_out_pkg::RST_OUT;
        end
      endcase
    end
  end

  // Output B: even leg of push-pull, the complement in skip-comp mode
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      b_q <= pwm_out_pkg::RST_OUT;
    end else if (!enable_i) begin
      b_q <= pwm_out_pkg::RST_OUT;
    end else begin
      unique case (mode_sel)
        pwm_out_pkg::MODE_PP_COMP,
        pwm_out_pkg::MODE_PP_FB6: begin
          if (db_r_fire && !rise_pair_q) begin
            b_q <= 1'b1;
          end else if (fall_evt_i && !odd_q) begin
            b_q <= 1'b0;
          end
        end
        pwm_out_pkg::MODE_PP_FB4: begin
          if (fall_evt_i && !odd_q) begin
            b_q <= 1'b0;
          end else if (rise_evt_i && !odd_q) begin
            b_q <= 1'b1;
          end
        end
        pwm_out_pkg::MODE_SKIP: begin
          b_q <= pwm_out_pkg::RST_OUT;
        end
        pwm_out_pkg::MODE_SKIP_COMP: begin
          if (db_f_fire) begin
            b_q <= 1'b1;
          end else if (db_r_start) begin
            b_q <= 1'b0;
          end
        end
        pwm_out_pkg::MODE_OFF: begin
          b_q <= pwm_out_pkg::RST_OUT;
        end
        default: begin
          b_q <= pwm_out_pkg::RST_OUT;
        end
      endcase
    end
  end

  // Complement E: odd leg, only in the two modes with a complement pair
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      e_q <= pwm_out_pkg::RST_OUT;
    end else if (!enable_i || !(is_comp | is_fb6)) begin
      e_q <= pwm_out_pkg::RST_OUT;
    end else if (db_f_fire && fall_pair_q) begin
      e_q <= 1'b1;
    end else if (rise_evt_i && odd_q) begin
      e_q <= 1'b0;
    end
  end

  // Complement F: even leg, only in the two modes with a complement pair
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      f_q <= pwm_out_pkg::RST_OUT;
    end else if (!enable_i || !(is_comp | is_fb6)) begin
      f_q <= pwm_out_pkg::RST_OUT;
    end else if (db_f_fire && !fall_pair_q) begin
      f_q <= 1'b1;
    end else if (rise_evt_i && !odd_q) begin
      f_q <= 1'b0;
    end
  end

  // Primary pins; C and D mirror A and B in the bridge modes only
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      drive_out_a_o <= pwm_out_pkg::RST_OUT;
      drive_out_b_o <= pwm_out_pkg::RST_OUT;
      drive_out_c_o <= pwm_out_pkg::RST_OUT;
      drive_out_d_o <= pwm_out_pkg::RST_OUT;
    end else begin
      drive_out_a_o <= a_q;
      drive_out_b_o <= b_q;
      drive_out_c_o <= is_bridge & a_q;
      drive_out_d_o <= is_bridge & b_q;
    end
  end

  // Complement pins
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      drive_out_e_o <= pwm_out_pkg::RST_OUT;
      drive_out_f_o <= pwm_out_pkg::RST_OUT;
    end else begin
      drive_out_e_o <= e_q;
      drive_out_f_o <= f_q;
    end
  end

  // Parity pin
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      odd_period_o <= pwm_out_pkg::RST_ODD;
    end else begin
      odd_period_o <= odd_q;
    end
  end

endmodule

// ===== tb/pwm_push_pull_out_properties.sv
module pwm_push_pull_out_properties (
  input wire logic       clk_sys_i,     // Unit clock
  input wire logic       reset_n_i,     // Reset, active low
  input wire logic       enable_i,      // Unit enable
  input wire logic [2:0] mode_i,        // Mode select
  input wire logic       period_evt_i,  // Period event
  input wire logic       rise_evt_i,    // Rising event
  input wire logic       fall_evt_i,    // Falling event
  input wire logic       drive_out_a_o, // Output A
  input wire logic       drive_out_b_o, // Output B
  input wire logic       drive_out_c_o, // Output C
  input wire logic       drive_out_d_o, // Output D
  input wire logic       drive_out_e_o, // Output E
  input wire logic       drive_out_f_o, // Output F
  input wire logic       odd_period_o   // Odd period flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  // Six-output odd leg: both low first, then A and C on
  sequence s_odd_gap;
    !drive_out_a_o && !drive_out_e_o;
  endsequence
  sequence s_odd_on;
    drive_out_a_o && drive_out_c_o && !drive_out_e_o;
  endsequence

  a_six_odd_rise: assert property (
    mode_i == 3'h3 && enable_i && rise_evt_i && odd_period_o
    |-> ##[1:3] s_odd_gap ##[1:20] s_odd_on)
    else $error("six-output odd rise out of order");
  a_bridge_c_copy: assert property (
    mode_i inside {3'h2, 3'h3} |-> drive_out_c_o == drive_out_a_o)
    else $error("output C differs from A");
  a_bridge_d_copy: assert property (
    mode_i inside {3'h2, 3'h3} |-> drive_out_d_o == drive_out_b_o)
    else $error("output D differs from B");
  a_legs_no_overlap: assert property (
    mode_i inside {3'h1, 3'h3} |-> !(drive_out_a_o && drive_out_e_o)
    && !(drive_out_b_o && drive_out_f_o))
    else $error("primary and complement both high");
  a_skip_comp_gap: assert property (
    mode_i == 3'h5 |-> !(drive_out_a_o && drive_out_b_o))
    else $error("skip outputs A and B both high");
  a_four_no_comp: assert property (
    mode_i == 3'h2 |-> !drive_out_e_o && !drive_out_f_o)
    else $error("four-output mode drives E or F");
  a_single_a_only: assert property (
    mode_i == 3'h4 |-> {drive_out_b_o, drive_out_c_o, drive_out_d_o,
    drive_out_e_o, drive_out_f_o} == 5'h00)
    else $error("single skip drives beyond A");
  a_four_odd_rise: assert property (
    mode_i == 3'h2 && enable_i && rise_evt_i && odd_period_o
    |-> ##[1:4] drive_out_a_o && drive_out_c_o)
    else $error("odd rise missed A and C");
  a_four_even_fall: assert property (
    mode_i == 3'h2 && enable_i && fall_evt_i && !odd_period_o
    |-> ##[1:4] !drive_out_b_o && !drive_out_d_o)
    else $error("even fall left B or D high");
  a_parity_toggle: assert property (
    enable_i && period_evt_i |-> ##[1:3] $changed(odd_period_o))
    else $error("parity did not toggle");
endmodule

// ===== tb/bridge_gate_model.sv
module bridge_gate_model (
  input  wire logic       clk_i,   // Bench clock
  input  wire logic [5:0] gate_i,  // Gate drives, F down to A
  input  wire logic [3:0] req_i,   // Wanted pulse sources
  output logic      [3:0] sense_o, // External pulse sources
  output int              fault_o  // Shoot-through count
);
  timeunit 1ns;
  timeprecision 1ps;
  initial sense_o = 4'h0;
  initial fault_o = 0;
  // Controller decides each pulse by its sources
  always @(negedge clk_i) sense_o <= req_i;
  // Both switches of one leg on is a fault
  always @(posedge clk_i)
    if ((gate_i[0] && gate_i[4]) || (gate_i[1] && gate_i[5]))
      fault_o <= fault_o + 1;
endmodule

// ===== tb/tb_pwm_push_pull_out.sv
module tb_pwm_push_pull_out;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        enable_i = 1'b0;
  logic [2:0]  mode_i = 3'h1;
  logic [2:0]  evt = 3'h0;
  logic [3:0]  src, src_en = 4'h0, req = 4'h0;
  logic [1:0]  db_en = 2'h0;
  logic [7:0]  db_len_r = 8'h00, db_len_f = 8'h00;
  logic [5:0]  pins, exp_pins = 6'h00;
  logic        odd_flag;
  logic [11:0] m;
  logic [31:0] lfsr = 32'h0001_1847; // Seed 71751
  int          num_errors = 0, tests_run = 0, fault;
  bit          odd, qual;

  always #2 clk_sys_i = ~clk_sys_i; // 250 MHz

  pwm_push_pull_out i_dut (
    .clk_sys_i     (clk_sys_i),
    .reset_n_i     (reset_n_i),
    .enable_i      (enable_i),
    .mode_i        (mode_i),
    .period_evt_i  (evt[0]),
    .rise_evt_i    (evt[1]),
    .fall_evt_i    (evt[2]),
    .rise_src_i    (src),
    .rise_src_en_i (src_en),
    .db_rise_en_i  (db_en[0]),
    .db_fall_en_i  (db_en[1]),
    .db_rise_len_i (db_len_r),
    .db_fall_len_i (db_len_f),
    .drive_out_a_o (pins[0]),
    .drive_out_b_o (pins[1]),
    .drive_out_c_o (pins[2]),
    .drive_out_d_o (pins[3]),
    .drive_out_e_o (pins[4]),
    .drive_out_f_o (pins[5]),
    .odd_period_o  (odd_flag)
  );

  bridge_gate_model i_gate (
    .clk_i   (clk_sys_i),
    .gate_i  (pins),
    .req_i   (req),
    .sense_o (src),
    .fault_o (fault)
  );

  function automatic logic [31:0] rnd();
    lfsr = {1'b0, lfsr[31:1]} ^ (lfsr[0] ? 32'h8020_0003 : 32'h0);
    return lfsr;
  endfunction

  task automatic check(input logic [5:0] seen, input logic [5:0] expd);
    tests_run++;
    if (seen !== expd) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expd);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Pulse one event, settle, update the model and compare
  task automatic ev(input int k);
    @(negedge clk_sys_i);
    evt[k] = 1'b1;
    @(negedge clk_sys_i);
    evt = 3'h0;
    repeat (40) @(negedge clk_sys_i);
    if (k == 0) begin
      odd = !odd;
      qual = |(req & src_en);
    end
    case (mode_i)
      3'h0: m = 12'h000;
      3'h1: m = odd ? 12'h050 : 12'h0a0;
      3'h2: m = odd ? 12'h140 : 12'h280;
      3'h3: m = odd ? 12'h150 : 12'h2a0;
      3'h4: m = 12'h040;
      default: m = 12'h042;
    endcase
    if (k == 1 && (mode_i < 3'h4 || qual))
      exp_pins = exp_pins & ~m[5:0] | m[11:6];
    if (k == 1)
      qual = 1'b0;
    if (k == 2)
      exp_pins = exp_pins & ~m[11:6] | m[5:0];
    check(pins, exp_pins);
  endtask

  // One mode: re-enable, then six periods with random settings
  task automatic run_mode(input logic [2:0] md);
    @(negedge clk_sys_i);
    enable_i = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    mode_i = md;
    db_en = 2'(rnd());
    db_len_r = 8'(rnd()) & 8'h0f;
    db_len_f = 8'(rnd()) & 8'h0f;
    enable_i = 1'b1;
    odd = 1'b1;
    qual = 1'b0;
    exp_pins = 6'h00;
    repeat (4) @(negedge clk_sys_i);
    check({5'h00, odd_flag}, 6'h01);
    for (int p = 0; p < 6; p++) begin
      req = (p == 2) ? 4'h0 : 4'(rnd());
      src_en = 4'(rnd());
      repeat (6) @(negedge clk_sys_i);
      if (p > 0)
        ev(0);
      if (p > 0 || md < 3'h4)
        ev(1);
      ev(2);
    end
    $display("mode %0d done, %0d errors", md, num_errors);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    for (int md = 0; md < 6; md++)
      run_mode(3'(md));
    check({5'h00, fault != 0}, 6'h00);
    finish_test();
  end

  // Watchdog
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    num_errors++;
    finish_test();
  end
endmodule

bind pwm_push_pull_out pwm_push_pull_out_properties i_props (
  .clk_sys_i     (clk_sys_i),
  .reset_n_i     (reset_n_i),
  .enable_i      (enable_i),
  .mode_i        (mode_i),
  .period_evt_i  (period_evt_i),
  .rise_evt_i    (rise_evt_i),
  .fall_evt_i    (fall_evt_i),
  .drive_out_a_o (drive_out_a_o),
  .drive_out_b_o (drive_out_b_o),
  .drive_out_c_o (drive_out_c_o),
  .drive_out_d_o (drive_out_d_o),
  .drive_out_e_o (drive_out_e_o),
  .drive_out_f_o (drive_out_f_o),
  .odd_period_o  (odd_period_o)
);
